// ===== tbl_regs.svh
// Purpose: shared constants of the table instruction engine
// Assumes: 16-bit data words, 4-digit octal bit references
// Notes:   definitions only
`ifndef TBL_REGS_SVH
`define TBL_REGS_SVH

// largest word count a table move accepts
`define TBL_MOVE_MAX_CNT  16'h0FFF
// largest table length for the bit operations
`define TBL_BIT_LEN_MAX   16'h00FF
// bits held by one data-memory word
`define TBL_WORD_BITS     16
// first offset of a program-memory copy
`define TBL_COPY_OFS_INIT 16'h0000
// reset value of every stored word
`define TBL_WORD_RST      16'h0000

`endif

// ===== tbl_pkg.sv
// Purpose: types shared by the sequencer end and the table engine
// Assumes: nothing
// Notes:   operations and states are one-hot
package tbl_pkg;

  // operations the sequencer issues
  typedef enum logic [3:0] {
    table_move_op          = 4'h1,
    program_memory_copy_op = 4'h2,
    bit_set_op             = 4'h4,
    bit_clear_op           = 4'h8
  } op_e;

  // engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'h1,
    ENG_XFER = 2'h2
  } eng_e;

  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h1,
    SEQ_WAIT = 2'h2
  } seq_e;

endpackage : tbl_pkg

// ===== tbl_if.sv
// Purpose: link between the instruction sequencer and the table engine
// Assumes: both ends run on the same clock
// Notes:   operands stand while req is high
`timescale 1ns/1ns
interface tbl_if;
  logic              req;              // one-cycle issue pulse
  tbl_pkg::op_e      op;               // operation
  logic [31:0]       acc;              // accumulator
  logic [31:0]       stk1;             // first stack level
  logic [31:0]       stk2;             // second stack level
  logic [15:0]       operand;          // instruction operand
  logic              load_label_ref_op; // accumulator holds a label reference
  logic              scan_end;         // end-of-scan pulse
  logic              busy;             // engine working
  logic              done;             // one-cycle completion pulse
  logic              range_error_flag; // range error of the last operation

  modport engine (
    input  req, op, acc, stk1, stk2, operand, load_label_ref_op, scan_end,
    output busy, done, range_error_flag
  );
  modport sequencer (
    output req, op, acc, stk1, stk2, operand, load_label_ref_op, scan_end,
    input  busy, done, range_error_flag
  );
endinterface : tbl_if

// ===== octal_bit_locate.sv
// Purpose: turn an octal bit reference into word index and bit position
// Assumes: reference holds four octal digits, one per nibble
// Notes:   combinational
`timescale 1ns/1ns
`include "tbl_regs.svh"
module octal_bit_locate (
  // reference and table length
  input  wire logic [15:0] i_ref,
  input  wire logic [15:0] i_len,
  // location
  output logic      [11:0] o_word,
  output logic      [3:0]  o_bit,
  output logic             o_bad
);
  logic [11:0] idx;
  logic        bad_digit;
  logic [19:0] bit_lim;

  // octal digits to binary bit index, counted from bit 0 of word 0
  assign idx       = {i_ref[14:12], i_ref[10:8], i_ref[6:4], i_ref[2:0]};
  assign bad_digit = i_ref[15] | i_ref[11] | i_ref[7] | i_ref[3];
  assign bit_lim   = {i_len, 4'h0};   // length times sixteen bits
  assign o_word    = {4'h0, idx[11:4]};
  assign o_bit     = idx[3:0];
  // beyond the last table bit, bad digit or over-long table
  assign o_bad     = bad_digit | ({8'h00, idx} >= bit_lim) | (i_len > `TBL_BIT_LEN_MAX);
endmodule : octal_bit_locate

// ===== tbl_engine.sv
// Purpose: table engine: move, program-memory copy, bit set and bit clear
// Assumes: sequencer keeps operands valid during req; one word per clock
// Notes:   data memory and label area are flip-flops with a user port
// Behaviour
// R1: move copies every source word to destination
// R2: issuer gives move count, at most maximum
// R3: move source from accumulator, destination from operand
// R4: moves may write the non-volatile region
// R5: move operand too large raises range error
// R6: issuer gives copy count in second level
// R7: one offset applies to both copy areas
// R8: accumulator holds label reference or data address
// R9: label reference only for copies into data
// R10: copy writes data destination from operand
// R11: offset starts at zero; overrun gives undefined data
// R12: bit set forces one addressed bit high
// R13: bit clear forces one addressed bit low
// R14: issuer gives bit table length, hex count
// R15: issuer gives bit table start in accumulator
// R16: octal bit reference, sixteen bits per word
// R17: bit beyond table flags error, modifies nothing
// R18: flag holds until scan end or next operation
// R19: words outside the target stay untouched
`timescale 1ns/1ns
`include "tbl_regs.svh"
module tbl_engine #(
  parameter int DEPTH     = 1024,  // data-memory words
  parameter int LBL_DEPTH = 256,   // label-area words
  parameter int NV_BASE   = 512    // first non-volatile data word
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // link to the sequencer
  tbl_if.engine            bus,
  // user access to storage while idle
  input  wire logic        i_mem_we,
  input  wire logic        i_mem_label,
  input  wire logic [15:0] i_mem_addr,
  input  wire logic [15:0] i_mem_wdata,
  output logic      [15:0] o_mem_rdata
);
  localparam int IW = $clog2(DEPTH);
  localparam int LW = $clog2(LBL_DEPTH);
  localparam logic [16:0] MEM_LIM = 17'(DEPTH);
  localparam logic [16:0] LBL_LIM = 17'(LBL_DEPTH);

  // refuse sizes the 16-bit addressing cannot serve
  if (DEPTH < 2 || DEPTH > 65536 || LBL_DEPTH < 2 || LBL_DEPTH > 65536
      || NV_BASE > DEPTH) begin : g_chk
    $error("tbl_engine: bad memory sizes");
  end

  typedef struct packed {
    tbl_pkg::eng_e                 st;
    logic [15:0]                   src;
    logic [15:0]                   dst;
    logic [15:0]                   cnt;
    logic                          from_lbl;
    logic                          to_lbl;
    logic                          busy;
    logic                          done;
    logic                          err;
    logic [15:0]                   rdata;
    logic [LBL_DEPTH-1:0][15:0]    lbl;
    logic [DEPTH-1:0][15:0]        mem;
  } eng_s;

  eng_s        q;
  eng_s        d;
  logic [11:0] bit_word;
  logic [3:0]  bit_pos;
  logic        bit_bad;

  // bit reference decode
  octal_bit_locate u_locate (
    .i_ref  (bus.operand),
    .i_len  (bus.stk1[15:0]),
    .o_word (bit_word),
    .o_bit  (bit_pos),
    .o_bad  (bit_bad)
  );

  // next state of the engine and its storage
  always_comb begin
    logic [16:0] src_end;
    logic [16:0] dst_end;
    logic [16:0] ofs_src;
    logic [16:0] ofs_dst;
    logic [16:0] bit_addr;
    logic [15:0] word;
    src_end  = '0;
    dst_end  = '0;
    ofs_src  = {1'b0, bus.acc[15:0]} + {1'b0, bus.stk1[15:0]};
    ofs_dst  = {1'b0, bus.operand} + {1'b0, bus.stk1[15:0]};
    bit_addr = {1'b0, bus.acc[15:0]} + {5'h00, bit_word};
    word     = `TBL_WORD_RST;
    d        = q;
    d.done   = 1'b0;
    // end of scan ends the flag's validity; a new error below still wins
    if (bus.scan_end) begin
      d.err = 1'b0; // R18
    end
    // user read port, registered
    if (i_mem_label) begin
      d.rdata = ({1'b0, i_mem_addr} < LBL_LIM) ? q.lbl[i_mem_addr[LW-1:0]] : '0;
    end else begin
      d.rdata = ({1'b0, i_mem_addr} < MEM_LIM) ? q.mem[i_mem_addr[IW-1:0]] : '0;
    end
    case (q.st)
      tbl_pkg::ENG_IDLE: begin
        // user writes only while idle so they never race a transfer
        if (i_mem_we && !bus.req) begin
          if (i_mem_label && {1'b0, i_mem_addr} < LBL_LIM) begin
            d.lbl[i_mem_addr[LW-1:0]] = i_mem_wdata;
          end else if (!i_mem_label && {1'b0, i_mem_addr} < MEM_LIM) begin
            d.mem[i_mem_addr[IW-1:0]] = i_mem_wdata;
          end
        end
        if (bus.req) begin
          d.err = 1'b0; // R18
          case (bus.op)
            tbl_pkg::table_move_op: begin
              src_end    = {1'b0, bus.acc[15:0]} + {1'b0, bus.stk1[15:0]};
              dst_end    = {1'b0, bus.operand} + {1'b0, bus.stk1[15:0]};
              d.src      = bus.acc[15:0]; // R3
              d.dst      = bus.operand;   // R3
              d.cnt      = bus.stk1[15:0];
              d.from_lbl = 1'b0;
              d.to_lbl   = 1'b0;
              // whole data memory is writable, non-volatile part included
              if (bus.acc[31:16] != 16'h0000 || bus.stk1[31:16] != 16'h0000
                  || bus.stk1[15:0] > `TBL_MOVE_MAX_CNT
                  || src_end > MEM_LIM || dst_end > MEM_LIM) begin
                d.err  = 1'b1; // R5
                d.done = 1'b1;
              end else if (bus.stk1[15:0] == 16'h0000) begin
                d.done = 1'b1;
              end else begin
                d.st   = tbl_pkg::ENG_XFER; // R1 R4
                d.busy = 1'b1;
              end
            end
            tbl_pkg::program_memory_copy_op: begin
              // same offset into both areas
              d.src      = ofs_src[15:0]; // R7
              d.dst      = ofs_dst[15:0]; // R7 R10
              d.cnt      = bus.stk2[15:0];
              d.from_lbl = bus.load_label_ref_op; // R8
              d.to_lbl   = !bus.load_label_ref_op;
              dst_end    = ofs_dst + {1'b0, bus.stk2[15:0]};
              // destination is checked; a source overrun is let through
              if (ofs_src[16] || ofs_dst[16] || bus.stk2[31:16] != 16'h0000
                  || dst_end > (bus.load_label_ref_op ? MEM_LIM : LBL_LIM)) begin
                d.err  = 1'b1; // R19
                d.done = 1'b1;
              end else if (bus.stk2[15:0] == 16'h0000) begin
                d.done = 1'b1;
              end else begin
                d.st   = tbl_pkg::ENG_XFER;
                d.busy = 1'b1;
              end
            end
            tbl_pkg::bit_set_op,
            tbl_pkg::bit_clear_op: begin
              d.done = 1'b1;
              if (bit_bad || bus.acc[31:16] != 16'h0000 || bit_addr >= MEM_LIM) begin
                d.err = 1'b1; // R17
              end else begin
                d.mem[bit_addr[IW-1:0]][bit_pos] = (bus.op == tbl_pkg::bit_set_op); // R12 R13 R16
              end
            end
            default: begin
              d.done = 1'b1;
            end
          endcase
        end
      end
      tbl_pkg::ENG_XFER: begin
        // one word per clock, ascending addresses
        if (q.from_lbl) begin
          // beyond the label area the word is undefined; zero is supplied
          word = ({1'b0, q.src} < LBL_LIM) ? q.lbl[q.src[LW-1:0]] : '0; // R11
        end else begin
          word = ({1'b0, q.src} < MEM_LIM) ? q.mem[q.src[IW-1:0]] : '0;
        end
        if (q.to_lbl) begin
          d.lbl[q.dst[LW-1:0]] = word;
        end else begin
          d.mem[q.dst[IW-1:0]] = word; // R1 R10
        end
        d.src = q.src + 16'h0001;
        d.dst = q.dst + 16'h0001;
        d.cnt = q.cnt - 16'h0001;
        if (q.cnt == 16'h0001) begin
          d.st   = tbl_pkg::ENG_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end
      default: begin
        d.st   = tbl_pkg::ENG_IDLE;
        d.busy = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q    <= '0;
      q.st <= tbl_pkg::ENG_IDLE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign bus.busy             = q.busy;
  assign bus.done             = q.done;
  assign bus.range_error_flag = q.err;
  assign o_mem_rdata          = q.rdata;
endmodule : tbl_engine

// ===== tbl_sequencer.sv
// Purpose: instruction sequencer end: loads operands and issues table operations
// Assumes: user request stands on the cycle i_go is high
// Notes:   refuses operand sets the engine must not receive
`timescale 1ns/1ns
`include "tbl_regs.svh"
module tbl_sequencer (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  // user request
  input  wire logic         i_go,
  input  tbl_pkg::op_e      i_op,
  input  wire logic         i_from_label,
  input  wire logic [15:0]  i_src,
  input  wire logic [15:0]  i_dst,
  input  wire logic [15:0]  i_count,
  input  wire logic [15:0]  i_offset,
  input  wire logic         i_scan_end,
  // user status
  output logic              o_busy,
  output logic              o_done,
  output logic              o_range_error,
  output logic              o_refused,
  // link to the engine
  tbl_if.sequencer          bus
);
  typedef struct packed {
    tbl_pkg::seq_e st;
    logic          req;
    tbl_pkg::op_e  op;
    logic [31:0]   acc;
    logic [31:0]   stk1;
    logic [31:0]   stk2;
    logic [15:0]   operand;
    logic          label;
    logic          scan_end;
    logic          busy;
    logic          done;
    logic          err;
    logic          refused;
  } seq_s;

  seq_s q;
  seq_s d;

  // operand loading and completion tracking
  always_comb begin
    d          = q;
    d.req      = 1'b0;
    d.done     = 1'b0;
    d.refused  = 1'b0;
    d.scan_end = i_scan_end;
    case (q.st)
      tbl_pkg::SEQ_IDLE: begin
        if (i_go) begin
          d.op      = i_op;
          d.operand = i_dst;
          d.label   = 1'b0;
          d.stk2    = 32'h0000_0000;
          d.stk1    = {16'h0000, i_count};
          d.acc     = {16'h0000, i_src}; // R15
          if (i_op == tbl_pkg::program_memory_copy_op) begin
            d.stk2  = {16'h0000, i_count};  // R6
            d.stk1  = {16'h0000, i_offset}; // R7
            d.label = i_from_label;         // R8
          end
          if ((i_op == tbl_pkg::table_move_op && i_count > `TBL_MOVE_MAX_CNT) // R2
              || ((i_op == tbl_pkg::bit_set_op || i_op == tbl_pkg::bit_clear_op)
                  && i_count > `TBL_BIT_LEN_MAX)                          // R14
              || (i_from_label && i_op != tbl_pkg::program_memory_copy_op)) begin // R9
            d.refused = 1'b1;
            d.done    = 1'b1;
          end else begin
            d.req  = 1'b1; // R3
            d.busy = 1'b1;
            d.st   = tbl_pkg::SEQ_WAIT;
          end
        end
      end
      tbl_pkg::SEQ_WAIT: begin
        if (bus.done) begin
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st   = tbl_pkg::SEQ_IDLE;
        end
      end
      default: begin
        d.st   = tbl_pkg::SEQ_IDLE;
        d.busy = 1'b0;
      end
    endcase
    // flag follows the engine, which owns its lifetime
    d.err = bus.range_error_flag;
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q    <= '0;
      q.st <= tbl_pkg::SEQ_IDLE;
      q.op <= tbl_pkg::table_move_op;
    end else begin
      q <= d;
    end
  end

  // link and user outputs from flip-flops
  assign bus.req               = q.req;
  assign bus.op                = q.op;
  assign bus.acc               = q.acc;
  assign bus.stk1              = q.stk1;
  assign bus.stk2              = q.stk2;
  assign bus.operand           = q.operand;
  assign bus.load_label_ref_op = q.label;
  assign bus.scan_end          = q.scan_end;
  assign o_busy                = q.busy;
  assign o_done                = q.done;
  assign o_range_error         = q.err;
  assign o_refused             = q.refused;
endmodule : tbl_sequencer

// ===== tbl_sva.sv
// Purpose: checks on the link between the sequencer and the table engine
// Assumes: default engine depth of 1024 data words
// Notes:   instantiated beside the link by the bench
`timescale 1ns/1ns
module tbl_sva (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // link signals
  input  wire logic        req,
  input  tbl_pkg::op_e     op,
  input  wire logic [31:0] acc,
  input  wire logic [31:0] stk1,
  input  wire logic [15:0] operand,
  input  wire logic        scan_end,
  input  wire logic        busy,
  input  wire logic        done,
  input  wire logic        range_error_flag
);
  logic        bit_op;
  logic        ref_ok;
  logic [11:0] ref_idx;

  // bit operation issue and its decoded octal reference
  assign bit_op  = req && (op == tbl_pkg::bit_set_op || op == tbl_pkg::bit_clear_op);
  assign ref_ok  = !(operand[15] | operand[11] | operand[7] | operand[3]);
  assign ref_idx = {operand[14:12], operand[10:8], operand[6:4], operand[2:0]};

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_done_one_pulse: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  a_busy_ends_done: assert property ($fell(busy) |-> done)
    else $error("busy dropped without done");
  a_move_five_words: assert property (req && op == tbl_pkg::table_move_op && stk1 == 32'h5
      && acc < 32'd1000 && operand < 16'd1000 |=> busy [*5] ##1 (done && !busy))
    else $error("five word move took wrong time");
  a_move_over_max: assert property (req && op == tbl_pkg::table_move_op
      && (stk1 > 32'h0FFF || acc + stk1 > 32'd1024 || {16'h0000, operand} + stk1 > 32'd1024)
      |=> done && range_error_flag && !busy)
    else $error("oversize move count not flagged");
  a_bit_op_short: assert property (bit_op |=> done && !busy)
    else $error("bit operation not finished in one cycle");
  a_bit_beyond_table: assert property (bit_op && ref_ok && stk1 <= 32'hFF
      && ref_idx >= {stk1[7:0], 4'h0} |=> range_error_flag)
    else $error("bit beyond table not flagged");
  a_scan_clears_flag: assert property (scan_end && !req && !busy |=> !range_error_flag)
    else $error("scan end left flag set");
  a_flag_holds: assert property (!req && !scan_end && !busy |=> $stable(range_error_flag))
    else $error("flag changed without cause");
endmodule : tbl_sva

// ===== tb_table_move_bit_ops.sv
// Purpose: bench for the sequencer and table engine joined by their link
// Assumes: default engine depths; inputs change 1 ns after the clock edge
// Notes:   a second engine is driven directly to reach its error paths
`timescale 1ns/1ns
module tb_table_move_bit_ops;
  logic         i_mclk, i_rst_n, go, from_label, scan_pulse;
  logic         seq_busy, seq_done, seq_err, seq_refused, mem_we, mem_label;
  tbl_pkg::op_e op_sel;
  logic [15:0]  src, dst, cnt, ofs, mem_addr, mem_wdata, mem_rdata;
  int           error_cnt, check_count, k;

  tbl_if bus ();
  tbl_if bus_b ();

  tbl_sequencer u_tbl_sequencer (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_go(go), .i_op(op_sel),
    .i_from_label(from_label), .i_src(src), .i_dst(dst), .i_count(cnt), .i_offset(ofs),
    .i_scan_end(scan_pulse), .o_busy(seq_busy), .o_done(seq_done), .o_range_error(seq_err),
    .o_refused(seq_refused), .bus(bus.sequencer));
  tbl_engine u_tbl_engine (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(bus.engine),
    .i_mem_we(mem_we), .i_mem_label(mem_label), .i_mem_addr(mem_addr),
    .i_mem_wdata(mem_wdata), .o_mem_rdata(mem_rdata));
  tbl_engine u_tbl_engine_b (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(bus_b.engine),
    .i_mem_we(1'b0), .i_mem_label(1'b0), .i_mem_addr(16'h0000), .i_mem_wdata(16'h0000),
    .o_mem_rdata());
  tbl_sva u_tbl_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .req(bus.req), .op(bus.op),
    .acc(bus.acc), .stk1(bus.stk1), .operand(bus.operand), .scan_end(bus.scan_end),
    .busy(bus.busy), .done(bus.done), .range_error_flag(bus.range_error_flag));

  // clock of 4 ns period
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  task automatic tick;
    @(posedge i_mclk);
    #1;
  endtask : tick

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_flag

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // storage access through the idle user port
  task automatic mem_wr(input logic l, input logic [15:0] a, input logic [15:0] d);
    mem_label = l;
    mem_addr = a;
    mem_wdata = d;
    mem_we = 1'b1;
    tick();
    mem_we = 1'b0;
    tick();
  endtask : mem_wr

  task automatic mem_rd(input logic l, input logic [15:0] a, input logic [15:0] e);
    mem_label = l;
    mem_addr = a;
    tick();
    check_word(mem_rdata, e);
  endtask : mem_rd

  // one operation through the sequencer, with the link checked at issue
  task automatic run_op(input tbl_pkg::op_e o, input logic l, input logic [15:0] s, d, n, f);
    int i;
    op_sel = o;
    from_label = l;
    src = s;
    dst = d;
    cnt = n;
    ofs = f;
    go = 1'b1;
    tick();
    go = 1'b0;
    for (i = 0; i < 100 && seq_done !== 1'b1; i++) begin
      if (bus.req === 1'b1) begin
        check_word({12'h000, bus.op}, {12'h000, o});
        check_word(bus.acc[15:0], s);
        check_word(bus.operand, d);
        if (o == tbl_pkg::program_memory_copy_op) begin
          check_word(bus.stk2[15:0], n);
          check_word(bus.stk1[15:0], f);
          check_flag(bus.load_label_ref_op, l);
        end else begin
          check_word(bus.stk1[15:0], n);
        end
      end
      tick();
    end
    if (i == 100) begin
      error_cnt++;
      give_verdict();
    end
    check_flag(seq_busy, 1'b0);
  endtask : run_op

  // bad operand set sent straight to the second engine
  task automatic eng_b(input tbl_pkg::op_e o, input logic [31:0] a, c, input logic [15:0] r);
    int i;
    bus_b.op = o;
    bus_b.acc = a;
    bus_b.stk1 = c;
    bus_b.operand = r;
    bus_b.req = 1'b1;
    tick();
    bus_b.req = 1'b0;
    for (i = 0; i < 50 && bus_b.done !== 1'b1; i++) tick();
    if (i == 50) begin
      error_cnt++;
      give_verdict();
    end
    check_flag(bus_b.range_error_flag, 1'b1);
    tick();
  endtask : eng_b

  // main sequence
  initial begin
    {go, from_label, scan_pulse, mem_we, mem_label} = 5'h00;
    {src, dst, cnt, ofs, mem_addr, mem_wdata} = '0;
    op_sel = tbl_pkg::table_move_op;
    {bus_b.req, bus_b.scan_end, bus_b.load_label_ref_op} = 3'h0;
    {bus_b.acc, bus_b.stk1, bus_b.stk2, bus_b.operand} = '0;
    bus_b.op = tbl_pkg::table_move_op;
    error_cnt = 0;
    check_count = 0;
    i_rst_n = 1'b0;
    repeat (16) @(posedge i_mclk);
    #1;
    i_rst_n = 1'b1;
    tick();
    for (k = 0; k < 6; k++) mem_wr(1'b0, 16'h0010 + k[15:0], 16'hA5A0 + k[15:0]);
    mem_wr(1'b0, 16'h0205, 16'h1111);
    run_op(tbl_pkg::table_move_op, 1'b0, 16'h0010, 16'h0200, 16'h0005, 16'h0000);
    for (k = 0; k < 5; k++) mem_rd(1'b0, 16'h0200 + k[15:0], 16'hA5A0 + k[15:0]);
    mem_rd(1'b0, 16'h0205, 16'h1111);
    check_flag(seq_err, 1'b0);
    // source table running past the end of data memory is flagged, nothing written
    run_op(tbl_pkg::table_move_op, 1'b0, 16'h03FE, 16'h0100, 16'h0005, 16'h0000);
    check_flag(seq_err, 1'b1);
    // operand sets the sequencer must hold back
    run_op(tbl_pkg::table_move_op, 1'b0, 16'h0010, 16'h0100, 16'h1000, 16'h0000);
    check_flag(seq_refused, 1'b1);
    run_op(tbl_pkg::bit_set_op, 1'b1, 16'h0040, 16'h0000, 16'h0002, 16'h0000);
    check_flag(seq_refused, 1'b1);
    run_op(tbl_pkg::bit_set_op, 1'b0, 16'h0040, 16'h0000, 16'h0100, 16'h0000);
    check_flag(seq_refused, 1'b1);
    mem_rd(1'b0, 16'h0100, 16'h0000);
    $display("test move finished");
    for (k = 0; k < 4; k++) mem_wr(1'b1, k[15:0], 16'hC000 + k[15:0]);
    run_op(tbl_pkg::program_memory_copy_op, 1'b1, 16'h0000, 16'h0300, 16'h0003, 16'h0001);
    for (k = 1; k < 4; k++) mem_rd(1'b0, 16'h0300 + k[15:0], 16'hC000 + k[15:0]);
    mem_rd(1'b0, 16'h0300, 16'h0000);
    run_op(tbl_pkg::program_memory_copy_op, 1'b0, 16'h0010, 16'h0020, 16'h0002, 16'h0000);
    mem_rd(1'b1, 16'h0020, 16'hA5A0);
    mem_rd(1'b1, 16'h0021, 16'hA5A1);
    mem_rd(1'b1, 16'h0022, 16'h0000);
    $display("test copy finished");
    mem_wr(1'b0, 16'h0040, 16'h0F0F);
    mem_wr(1'b0, 16'h0041, 16'h0F0F);
    run_op(tbl_pkg::bit_set_op, 1'b0, 16'h0040, 16'h0034, 16'h0002, 16'h0000);
    run_op(tbl_pkg::bit_clear_op, 1'b0, 16'h0040, 16'h0003, 16'h0002, 16'h0000);
    run_op(tbl_pkg::bit_set_op, 1'b0, 16'h0040, 16'h0037, 16'h0002, 16'h0000);
    run_op(tbl_pkg::bit_clear_op, 1'b0, 16'h0040, 16'h0040, 16'h0002, 16'h0000);
    check_flag(seq_err, 1'b1);
    mem_rd(1'b0, 16'h0040, 16'h0F07);
    mem_rd(1'b0, 16'h0041, 16'h9F0F);
    mem_rd(1'b0, 16'h0042, 16'h0000);
    scan_pulse = 1'b1;
    tick();
    scan_pulse = 1'b0;
    repeat (3) tick();
    check_flag(seq_err, 1'b0);
    $display("test bit finished");
    eng_b(tbl_pkg::table_move_op, 32'h0000_0010, 32'h0000_1000, 16'h0200);
    eng_b(tbl_pkg::table_move_op, 32'h0001_0000, 32'h0000_0001, 16'h0200);
    eng_b(tbl_pkg::bit_set_op, 32'h0000_0040, 32'h0000_0002, 16'h0040);
    eng_b(tbl_pkg::bit_clear_op, 32'h0000_0040, 32'h0000_0002, 16'h0008);
    bus_b.scan_end = 1'b1;
    tick();
    bus_b.scan_end = 1'b0;
    tick();
    check_flag(bus_b.range_error_flag, 1'b0);
    $display("test range error finished");
    give_verdict();
  end
endmodule : tb_table_move_bit_ops
